// ==== logic/ctcm_top.sv ====
// Two counter/timer instances with capture, match and APB registers.
// Assumes one 40 MHz clock, APB on that clock, capture pins asynchronous.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module ctcm_top (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ctcm_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [ctcm_pkg::CNT_W-1:0] i_pwdata,
    input wire logic [ctcm_pkg::NUM_PIN-1:0] i_capture,
    output logic [ctcm_pkg::CNT_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [ctcm_pkg::NUM_OUT-1:0] o_match,
    output logic [ctcm_pkg::NUM_OUT-1:0] o_dma_req,
    output logic o_irq
);
    import ctcm_pkg::*;

    function automatic logic edge_sel(input logic [1:0] how,
                                      input logic r, input logic f);
        edge_sel = (how[0] & r) | (how[1] & f);
    endfunction

    ctcm_apb_e apb_state_reg;
    logic [CNT_W-1:0] tc_reg [NUM_INST];
    logic [CNT_W-1:0] pc_reg [NUM_INST];
    logic [CNT_W-1:0] pr_reg [NUM_INST];
    logic [CNT_W-1:0] mr_reg [NUM_INST][NUM_MATCH];
    logic [CNT_W-1:0] cr_reg [NUM_INST][NUM_CAP];
    logic [CTRL_W-1:0] ctrl_reg [NUM_INST];
    logic [NUM_MATCH*MC_W-1:0] mcr_reg [NUM_INST];
    logic [NUM_CAP*CC_W-1:0] ccr_reg [NUM_INST];
    logic [CM_W-1:0] cm_reg [NUM_INST];
    logic [EC_W-1:0] ec_reg [NUM_INST];
    logic [STS_W-1:0] sts_reg [NUM_INST];
    logic [STS_W-1:0] msk_reg [NUM_INST];
    logic [NUM_PIN-1:0] rise;
    logic [NUM_PIN-1:0] fall;
    logic [NUM_INST-1:0] tick;
    logic [NUM_INST-1:0] adv;
    logic [NUM_INST-1:0] clr_ev;
    logic [NUM_INST-1:0] mrst_hit;
    logic [NUM_INST-1:0] stop_hit;
    logic [NUM_MATCH-1:0] mev [NUM_INST];
    logic [NUM_CAP-1:0] cev [NUM_INST];
    logic [STS_W-1:0] set_ev [NUM_INST];
    logic [NUM_INST-1:0] wsel;
    logic wr_en;
    logic take;
    logic addr_bad;
    logic [3:0] idx;
    logic inst;
    logic [CNT_W-1:0] rd_data;

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PIN; gp++) begin : g_pin
            ctcm_pin_sync u_sync (
                .i_clock(i_clock),
                .i_rst_n(i_rst_n),
                .i_pin(i_capture[gp]),
                .o_rise(rise[gp]),
                .o_fall(fall[gp])
            );
        end
    endgenerate

    // Bus decode; the answer comes one cycle into the access phase.
    assign idx = i_paddr[IDX_MSB:IDX_LSB];
    assign inst = i_paddr[INST_BIT];
    assign addr_bad = |i_paddr[ADDR_W-1:UPPER_LSB];
    assign take = i_psel & i_penable & (apb_state_reg == APB_IDLE);
    assign wr_en = i_psel & i_penable & i_pwrite & ~addr_bad &
                   (apb_state_reg == APB_RESP);

    always_comb begin
        for (int i = 0; i < NUM_INST; i++) begin
            wsel[i] = wr_en & (inst == 1'(i));
        end
    end

    // Per-instance event decode.
    always_comb begin
        for (int i = 0; i < NUM_INST; i++) begin
            logic [1:0] mode;
            logic sr;
            logic sf;
            logic hit;
            hit = 1'b0;
            mode = cm_reg[i][CM_MODE +: 2];
            sr = rise[i*NUM_CAP + int'(cm_reg[i][CM_SEL])];
            sf = fall[i*NUM_CAP + int'(cm_reg[i][CM_SEL])];
            // Timer mode ticks every clock, counter mode on chosen edges.
            tick[i] = ctrl_reg[i][CTRL_EN] &
                      ((mode == 2'b00) | edge_sel(mode, sr, sf));
            adv[i] = tick[i] & (pc_reg[i] == pr_reg[i]);
            mrst_hit[i] = 1'b0;
            stop_hit[i] = 1'b0;
            for (int m = 0; m < NUM_MATCH; m++) begin
                hit = adv[i] & (tc_reg[i] == mr_reg[i][m]);
                mev[i][m] = hit;
                mrst_hit[i] = mrst_hit[i] |
                              (hit & mcr_reg[i][m*MC_W+MC_RST]);
                stop_hit[i] = stop_hit[i] |
                              (hit & mcr_reg[i][m*MC_W+MC_STOP]);
                set_ev[i][m] = hit & mcr_reg[i][m*MC_W+MC_INT];
            end
            for (int c = 0; c < NUM_CAP; c++) begin
                cev[i][c] = edge_sel(ccr_reg[i][c*CC_W +: 2],
                                     rise[i*NUM_CAP+c],
                                     fall[i*NUM_CAP+c]);
                set_ev[i][STS_CAP_LSB+c] = cev[i][c] &
                                           ccr_reg[i][c*CC_W+CC_INT];
            end
            sr = rise[i*NUM_CAP + int'(cm_reg[i][CM_CLR_CH])];
            sf = fall[i*NUM_CAP + int'(cm_reg[i][CM_CLR_CH])];
            clr_ev[i] = cm_reg[i][CM_CLR_EN] &
                        (cm_reg[i][CM_CLR_FALL] ? sf : sr);
        end
    end

    // Read mux.
    always_comb begin
        rd_data = RDATA_UNMAPPED;
        case (idx)
            IDX_STATUS: rd_data = CNT_W'(sts_reg[inst]);
            IDX_CTRL: rd_data = CNT_W'(ctrl_reg[inst]);
            IDX_TC: rd_data = tc_reg[inst];
            IDX_PRESCALE: rd_data = pr_reg[inst];
            IDX_PCOUNT: rd_data = pc_reg[inst];
            IDX_MATCH_CTRL: rd_data = CNT_W'(mcr_reg[inst]);
            IDX_CAP_CTRL: rd_data = CNT_W'(ccr_reg[inst]);
            IDX_EXT_CTRL: rd_data = CNT_W'({ec_reg[inst], 2'b00,
                o_match[int'(inst)*NUM_EXT +: NUM_EXT]});
            IDX_COUNT_CTRL: rd_data = CNT_W'(cm_reg[inst]);
            IDX_MASK: rd_data = CNT_W'(msk_reg[inst]);
            default: begin
                for (int m = 0; m < NUM_MATCH; m++) begin
                    if (idx == 4'(IDX_MATCH0 + m)) begin
                        rd_data = mr_reg[inst][m];
                    end
                end
                for (int c = 0; c < NUM_CAP; c++) begin
                    if (idx == 4'(IDX_CAP0 + c)) begin
                        rd_data = cr_reg[inst][c];
                    end
                end
            end
        endcase
    end

    // APB slave: response registered, so every bus output is a flop.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            apb_state_reg <= APB_IDLE;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= ZERO_WORD;
        end else begin
            case (apb_state_reg)
                APB_IDLE: begin
                    if (take) begin
                        apb_state_reg <= APB_RESP;
                        o_pready <= 1'b1;
                        o_pslverr <= addr_bad;
                        o_prdata <= addr_bad ? RDATA_UNMAPPED : rd_data;
                    end
                end
                APB_RESP: begin
                    apb_state_reg <= APB_IDLE;
                    o_pready <= 1'b0;
                    o_pslverr <= 1'b0;
                end
                default: begin
                    apb_state_reg <= APB_IDLE;
                    o_pready <= 1'b0;
                end
            endcase
        end
    end

    // Configuration registers, one set per instance.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NUM_INST; i++) begin
                pr_reg[i] <= ZERO_WORD;
                mcr_reg[i] <= '0;
                ccr_reg[i] <= '0;
                cm_reg[i] <= '0;
                ec_reg[i] <= '0;
                msk_reg[i] <= '0;
                for (int m = 0; m < NUM_MATCH; m++) begin
                    mr_reg[i][m] <= ZERO_WORD;
                end
            end
        end else begin
            for (int i = 0; i < NUM_INST; i++) begin
                if (wsel[i]) begin
                    case (idx)
                        IDX_PRESCALE: pr_reg[i] <= i_pwdata;
                        IDX_MATCH_CTRL:
                            mcr_reg[i] <= i_pwdata[NUM_MATCH*MC_W-1:0];
                        IDX_CAP_CTRL:
                            ccr_reg[i] <= i_pwdata[NUM_CAP*CC_W-1:0];
                        IDX_COUNT_CTRL: cm_reg[i] <= i_pwdata[CM_W-1:0];
                        IDX_EXT_CTRL:
                            ec_reg[i] <= i_pwdata[EC_LSB +: EC_W];
                        IDX_MASK: msk_reg[i] <= i_pwdata[STS_W-1:0];
                        default: begin
                            for (int m = 0; m < NUM_MATCH; m++) begin
                                if (idx == 4'(IDX_MATCH0 + m)) begin
                                    mr_reg[i][m] <= i_pwdata;
                                end
                            end
                        end
                    endcase
                end
            end
        end
    end

    // Control: a stop-on-match clears enable unless software writes it.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NUM_INST; i++) begin
                ctrl_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_INST; i++) begin
                if (wsel[i] && idx == IDX_CTRL) begin
                    ctrl_reg[i] <= i_pwdata[CTRL_W-1:0];
                end else if (stop_hit[i]) begin
                    ctrl_reg[i][CTRL_EN] <= 1'b0;
                end
            end
        end
    end

    // Count and prescaler. Reset-on-match wins over the increment.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NUM_INST; i++) begin
                tc_reg[i] <= ZERO_WORD;
                pc_reg[i] <= ZERO_WORD;
            end
        end else begin
            for (int i = 0; i < NUM_INST; i++) begin
                if (ctrl_reg[i][CTRL_RST] || clr_ev[i]) begin
                    tc_reg[i] <= ZERO_WORD;
                    pc_reg[i] <= ZERO_WORD;
                end else if (wsel[i] && idx == IDX_TC) begin
                    tc_reg[i] <= i_pwdata;
                end else if (wsel[i] && idx == IDX_PCOUNT) begin
                    pc_reg[i] <= i_pwdata;
                end else if (tick[i]) begin
                    if (adv[i]) begin
                        pc_reg[i] <= ZERO_WORD;
                        tc_reg[i] <= mrst_hit[i] ? ZERO_WORD
                                   : tc_reg[i] + ONE_WORD;
                    end else begin
                        pc_reg[i] <= pc_reg[i] + ONE_WORD;
                    end
                end
            end
        end
    end

    // Capture registers take the count seen at the detected edge.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NUM_INST; i++) begin
                for (int c = 0; c < NUM_CAP; c++) begin
                    cr_reg[i][c] <= ZERO_WORD;
                end
            end
        end else begin
            for (int i = 0; i < NUM_INST; i++) begin
                for (int c = 0; c < NUM_CAP; c++) begin
                    if (cev[i][c]) begin
                        cr_reg[i][c] <= tc_reg[i];
                    end
                end
            end
        end
    end

    // Sticky flags; a new event in the clearing cycle keeps its flag.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NUM_INST; i++) begin
                sts_reg[i] <= '0;
            end
            o_irq <= 1'b0;
        end else begin
            o_irq <= |((sts_reg[0] & msk_reg[0]) |
                       (sts_reg[1] & msk_reg[1]));
            for (int i = 0; i < NUM_INST; i++) begin
                if (wsel[i] && idx == IDX_STATUS) begin
                    sts_reg[i] <= (sts_reg[i] & ~i_pwdata[STS_W-1:0]) |
                                  set_ev[i];
                end else begin
                    sts_reg[i] <= sts_reg[i] | set_ev[i];
                end
            end
        end
    end

    // Match pins and DMA pulses. Software may also write the pin state.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_match <= '0;
            o_dma_req <= '0;
        end else begin
            for (int i = 0; i < NUM_INST; i++) begin
                for (int e = 0; e < NUM_EXT; e++) begin
                    o_dma_req[i*NUM_EXT+e] <= mev[i][e];
                    if (wsel[i] && idx == IDX_EXT_CTRL) begin
                        o_match[i*NUM_EXT+e] <= i_pwdata[e];
                    end else if (mev[i][e]) begin
                        case (ctcm_ext_e'(ec_reg[i][2*e +: 2]))
                            EXT_LOW: o_match[i*NUM_EXT+e] <= 1'b0;
                            EXT_HIGH: o_match[i*NUM_EXT+e] <= 1'b1;
                            EXT_TOGGLE: o_match[i*NUM_EXT+e] <=
                                ~o_match[i*NUM_EXT+e];
                            default: o_match[i*NUM_EXT+e] <=
                                o_match[i*NUM_EXT+e];
                        endcase
                    end
                end
            end
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence s_access;
        i_psel && i_penable && !o_pready;
    endsequence
    sequence s_answer;
        o_pready ##1 !o_pready;
    endsequence

    a_apb_answer: assert property (s_access |=> s_answer)
        else $error("APB answer not one cycle after access");
    a_capture_load: assert property (cev[0][0] |=>
        cr_reg[0][0] == $past(tc_reg[0]))
        else $error("Capture did not latch the count");
    a_capture_flag: assert property (cev[0][1] && ccr_reg[0][5]
        |=> sts_reg[0][5])
        else $error("Capture flag not set");
    a_match_reset: assert property (mrst_hit[0] && !wsel[0]
        |=> tc_reg[0] == ZERO_WORD)
        else $error("Count not reset on match");
    a_match_stop: assert property (stop_hit[0] && !wsel[0] |=>
        !ctrl_reg[0][CTRL_EN] ##1 tc_reg[0] == $past(tc_reg[0]))
        else $error("Timer not stopped on match");
    a_prescale_wrap: assert property (adv[1] && !clr_ev[1]
        && !ctrl_reg[1][CTRL_RST] && !wsel[1] |=> pc_reg[1] == ZERO_WORD)
        else $error("Prescaler did not wrap");
    a_clear_capture: assert property (clr_ev[0] |=>
        tc_reg[0] == ZERO_WORD && pc_reg[0] == ZERO_WORD)
        else $error("Capture clear missed");
    a_dma_pulse: assert property (mev[1][1] |=>
        o_dma_req[3] ##1 (o_dma_req[3] == $past(mev[1][1])))
        else $error("DMA request not pulsed");
    a_ext_toggle: assert property (mev[0][0] && !wsel[0]
        && ec_reg[0][1:0] == EXT_TOGGLE |=> o_match[0] != $past(o_match[0]))
        else $error("Match pin did not toggle");
    a_irq_level: assert property ((sts_reg[0] & msk_reg[0]) != '0
        |=> o_irq)
        else $error("Interrupt not raised");
endmodule

// ==== logic/ctcm_pkg.sv ====
// Shared constants for the dual counter/timer with capture and match.
// Assumes an APB master on the same clock as the timer logic.
package ctcm_pkg;
    localparam int NUM_INST = 2;
    localparam int NUM_CAP = 2;
    localparam int NUM_MATCH = 4;
    localparam int NUM_EXT = 2;
    localparam int CNT_W = 32;
    localparam int ADDR_W = 12;
    localparam int NUM_PIN = NUM_INST * NUM_CAP;
    localparam int NUM_OUT = NUM_INST * NUM_EXT;
    // Address layout: word index in bits 5:2, instance in bit 6.
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 5;
    localparam int INST_BIT = 6;
    localparam int UPPER_LSB = 7;
    localparam logic [3:0] IDX_STATUS = 4'h0;
    localparam logic [3:0] IDX_CTRL = 4'h1;
    localparam logic [3:0] IDX_TC = 4'h2;
    localparam logic [3:0] IDX_PRESCALE = 4'h3;
    localparam logic [3:0] IDX_PCOUNT = 4'h4;
    localparam logic [3:0] IDX_MATCH_CTRL = 4'h5;
    localparam logic [3:0] IDX_MATCH0 = 4'h6;
    localparam logic [3:0] IDX_CAP_CTRL = 4'hA;
    localparam logic [3:0] IDX_CAP0 = 4'hB;
    localparam logic [3:0] IDX_EXT_CTRL = 4'hD;
    localparam logic [3:0] IDX_COUNT_CTRL = 4'hE;
    localparam logic [3:0] IDX_MASK = 4'hF;
    // Control register fields.
    localparam int CTRL_EN = 0;
    localparam int CTRL_RST = 1;
    localparam int CTRL_W = 2;
    // Match control: three bits per match register.
    localparam int MC_INT = 0;
    localparam int MC_RST = 1;
    localparam int MC_STOP = 2;
    localparam int MC_W = 3;
    // Capture control: three bits per capture channel.
    localparam int CC_RISE = 0;
    localparam int CC_FALL = 1;
    localparam int CC_INT = 2;
    localparam int CC_W = 3;
    // Count control fields.
    localparam int CM_MODE = 0;
    localparam int CM_SEL = 2;
    localparam int CM_CLR_EN = 3;
    localparam int CM_CLR_CH = 4;
    localparam int CM_CLR_FALL = 5;
    localparam int CM_W = 6;
    // External match control: state in bits 1:0, actions from bit 4.
    localparam int EC_LSB = 4;
    localparam int EC_W = 2 * NUM_EXT;
    // Status and mask: matches in bits 3:0, captures in bits 5:4.
    localparam int STS_CAP_LSB = 4;
    localparam int STS_W = NUM_MATCH + NUM_CAP;
    localparam logic [CNT_W-1:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [CNT_W-1:0] ONE_WORD = 32'h0000_0001;
    localparam logic [CNT_W-1:0] RDATA_UNMAPPED = 32'h0000_0000;
    typedef enum logic [1:0] {
        EXT_NONE = 2'b00,
        EXT_LOW = 2'b01,
        EXT_HIGH = 2'b10,
        EXT_TOGGLE = 2'b11
    } ctcm_ext_e;
    typedef enum logic {
        APB_IDLE = 1'b0,
        APB_RESP = 1'b1
    } ctcm_apb_e;
endpackage

// ==== logic/ctcm_pin_sync.sv ====
// Two-flop synchroniser with edge detection for one capture pin.
// Assumes the pin is asynchronous to i_clock.
`timescale 1ns/10ps
module ctcm_pin_sync (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_pin,
    output logic o_rise,
    output logic o_fall
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= i_pin;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Only the second flop and its delayed copy feed the edge logic.
    assign o_rise = sync_reg & ~prev_reg;
    assign o_fall = ~sync_reg & prev_reg;
endmodule

// ==== verif/ctcm_pin_model.sv ====
// Far-side model: drives the capture pins and records which match pins have been high.
// Assumes the bench asks for pin levels between clock edges.
`timescale 1ns/10ps
module ctcm_pin_model (
    input wire logic i_clock,
    input wire logic [ctcm_pkg::NUM_PIN-1:0] i_level,
    input wire logic [ctcm_pkg::NUM_OUT-1:0] i_match,
    output logic [ctcm_pkg::NUM_PIN-1:0] o_capture,
    output logic [ctcm_pkg::NUM_OUT-1:0] o_seen_high
);
    import ctcm_pkg::*;
    initial o_capture = '0;
    initial o_seen_high = '0;
    // Pins move only on a clock edge, like a registered external source.
    always @(posedge i_clock) begin
        o_capture <= i_level;
        o_seen_high <= o_seen_high | i_match;
    end
endmodule

// ==== verif/counter_timer_capture_match_tb.sv ====
// Self-checking bench for the dual counter/timer over APB.
// Assumes the pin model stands on the capture and match pins.
`timescale 1ns/10ps
module counter_timer_capture_match_tb;
    import ctcm_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, irq, rdy, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwd = 32'h0000_0000, prd;
    logic [3:0] lvl = 4'h0, cap, mat, dma, seen, dma_seen = 4'h0;
    int failures = 0, n_checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    ctcm_top DUT (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd),
        .i_capture(cap), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
        .o_match(mat), .o_dma_req(dma), .o_irq(irq));
    ctcm_pin_model pins (.i_clock(clk), .i_level(lvl), .i_match(mat),
        .o_capture(cap), .o_seen_high(seen));
    always @(posedge clk) begin
        dma_seen <= dma_seen | dma;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    function automatic logic [11:0] ad(input logic i, input logic [3:0] x);
        return {5'h00, i, x, 2'b00};
    endfunction
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1);
        chk("pready_wait", 32'h0000_0002, n);
        r = prd;
        e = err;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1, a, d, r, e);
    endtask
    task automatic rd(input string s, input logic [11:0] a,
        input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(0, a, 32'h0000_0000, r, e);
        chk(s, x, r);
    endtask
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd("ctrl", ad(0, IDX_CTRL), 32'h0000_0000);
        rd("prescale", ad(1, IDX_PRESCALE), 32'h0000_0000);
        apb(0, 12'h080, 32'h0000_0000, r, e);
        chk("unmapped_err", 1, {31'b0, e});
        $display("test reset done");
    endtask
    task automatic t_stop();
        wr(ad(0, IDX_MATCH0), 32'h0000_0005);
        wr(ad(0, IDX_MATCH_CTRL), 32'h0000_0005);
        wr(ad(0, IDX_MASK), 32'h0000_0001);
        wr(ad(0, IDX_EXT_CTRL), 32'h0000_0020);
        wr(ad(0, IDX_CTRL), 32'h0000_0001);
        repeat (40) @(posedge clk);
        chk("irq", 1, {31'b0, irq});
        chk("match_pin", 1, {31'b0, mat[0]});
        chk("seen_high", 1, {31'b0, seen[0]});
        chk("dma", 1, {31'b0, dma_seen[0]});
        // The stop edge still advances the count once past the match.
        rd("tc_stop", ad(0, IDX_TC), 32'h0000_0006);
        rd("ctrl_stop", ad(0, IDX_CTRL), 32'h0000_0000);
        rd("sts", ad(0, IDX_STATUS), 32'h0000_0001);
        wr(ad(0, IDX_TC), 32'h0000_0000);
        wr(ad(0, IDX_EXT_CTRL), 32'h0000_0031);
        wr(ad(0, IDX_CTRL), 32'h0000_0001);
        repeat (20) @(posedge clk);
        chk("toggle_pin", 0, {31'b0, mat[0]});
        wr(ad(0, IDX_STATUS), 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk("irq_clr", 0, {31'b0, irq});
        $display("test stop done");
    endtask
    task automatic t_wrap();
        logic [31:0] r;
        logic e;
        wr(ad(0, IDX_TC), 32'h0000_0000);
        wr(ad(0, IDX_MATCH0 + 4'h1), 32'h0000_0003);
        wr(ad(0, IDX_MATCH_CTRL), 32'h0000_0018);
        wr(ad(0, IDX_CTRL), 32'h0000_0001);
        for (int k = 0; k < 5; k++) begin
            apb(0, ad(0, IDX_TC), 32'h0000_0000, r, e);
            chk("tc_wrap", 1, {31'b0, r <= 32'h0000_0003});
        end
        rd("sts_wrap", ad(0, IDX_STATUS), 32'h0000_0002);
        $display("test wrap done");
    endtask
    task automatic t_capture();
        logic [31:0] r;
        logic e;
        wr(ad(0, IDX_MATCH_CTRL), 32'h0000_0000);
        wr(ad(0, IDX_CAP_CTRL), 32'h0000_002D);
        repeat (20) @(posedge clk);
        lvl <= 4'h3;
        repeat (8) @(posedge clk);
        apb(0, ad(0, IDX_CAP0), 32'h0000_0000, r, e);
        chk("cap_nz", 1, {31'b0, r != 32'h0000_0000});
        apb(0, ad(0, IDX_CAP0 + 4'h1), 32'h0000_0000, r, e);
        chk("cap1_nz", 1, {31'b0, r != 32'h0000_0000});
        rd("sts_cap", ad(0, IDX_STATUS), 32'h0000_0032);
        lvl <= 4'h0;
        wr(ad(0, IDX_COUNT_CTRL), 32'h0000_0008);
        repeat (30) @(posedge clk);
        lvl <= 4'h1;
        repeat (6) @(posedge clk);
        apb(0, ad(0, IDX_TC), 32'h0000_0000, r, e);
        chk("tc_clear", 1, {31'b0, r < 32'h0000_000C});
        rd("inst1_tc", ad(1, IDX_TC), 32'h0000_0000);
        $display("test capture done");
    endtask
    task automatic t_counter();
        wr(ad(1, IDX_PRESCALE), 32'h0000_0001);
        wr(ad(1, IDX_COUNT_CTRL), 32'h0000_0001);
        wr(ad(1, IDX_CTRL), 32'h0000_0001);
        for (int k = 0; k < 4; k++) begin
            lvl <= 4'h5;
            repeat (5) @(posedge clk);
            lvl <= 4'h1;
            repeat (5) @(posedge clk);
        end
        rd("tc_ext", ad(1, IDX_TC), 32'h0000_0002);
        $display("test counter done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_reset();
        t_stop();
        t_wrap();
        t_capture();
        t_counter();
        final_report();
    end
endmodule
